/* File: tb/ost_ctrl_asserts.sv */
// Port-level checks for the self-test controller
`timescale 1ns/1ps
`include "ost_regs.svh"
module ost_ctrl_asserts
	import ost_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Host side
	input wire logic hcmd_valid,
	input wire logic [2:0] hcmd_kind,
	input wire logic soft_rst,
	input wire logic media_fail,
	// Status
	input wire ost_tf_s tf,
	input wire logic sleep_req,
	input wire logic standby_timer_ok,
	input wire logic scan_active
);
	// ----
	// Helpers
	// ----
	logic acc; // Access phase
	logic cap_go; // Captive start request
	logic en_q; // Mirror of SMART enable, guesses low
	assign acc = psel && penable;
	assign cap_go = acc && pwrite && paddr == `OST_CMD_OFF && pwdata[31]
		&& pwdata[7:0] inside {[8'h81:8'h84]} && en_q && !tf.bsy;
	// Track enable writes so refused starts are not checked
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			en_q <= 1'b0;
		end else if (acc && pwrite && paddr == `OST_CTRL_OFF) begin
			en_q <= pwdata[0];
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence busy_rise_s;
		##[1:3] tf.bsy;
	endsequence
	sequence busy_fall_s;
		##[1:1000] !tf.bsy;
	endsequence
	pready_on_a: assert property (acc |-> pready)
		else $error("ready missing in access");
	slverr_phase_a: assert property (pslverr |-> acc)
		else $error("error flag outside access");
	sleep_pulse_a: assert property ($rose(sleep_req) |=> !sleep_req)
		else $error("sleep request too long");
	sleep_exec_a: assert property (hcmd_valid && hcmd_kind == 3'h1
		|-> ##[1:3] sleep_req) else $error("sleep not executed");
	offline_flags_a: assert property (scan_active |-> !tf.bsy && tf.drdy)
		else $error("busy during off-line scan");
	power_hold_a: assert property (scan_active |-> !standby_timer_ok)
		else $error("standby allowed while scanning");
	cap_busy_a: assert property (cap_go |-> busy_rise_s)
		else $error("captive start without busy");
	cap_done_a: assert property ($rose(tf.bsy) |-> busy_fall_s)
		else $error("captive test never completes");
	suspend_a: assert property (hcmd_valid && scan_active
		&& hcmd_kind inside {3'h0, 3'h2, 3'h4, 3'h5} |-> ##[1:3] !scan_active)
		else $error("scan not suspended");
	scan_quiet_a: assert property (scan_active && media_fail
		|=> !$rose(tf.err)) else $error("scan error reported");
endmodule

bind ost_ctrl ost_ctrl_asserts u_chk (.*);

/* File: tb/ost_host_model.sv */
// Host controller model issuing non-execute commands
`timescale 1ns/1ps
module ost_host_model (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Bench request, slow adds a delay
	input wire logic go,
	input wire logic [2:0] kind,
	input wire logic slow,
	// Device busy: host holds off while set
	input wire logic bsy,
	// Command notice
	output logic hcmd_valid,
	output logic [2:0] hcmd_kind
);
	logic armed_q; // Command waiting
	logic [3:0] wait_q; // Issue delay
	logic [2:0] kind_q; // Latched kind
	logic fire; // Issue now
	assign fire = armed_q && wait_q == 4'h0 && !bsy && !go;
	// Request bookkeeping
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			armed_q <= 1'b0;
			wait_q <= 4'h0;
			kind_q <= 3'h0;
		end else if (go) begin
			armed_q <= 1'b1;
			wait_q <= slow ? 4'hA : 4'h0;
			kind_q <= kind;
		end else if (armed_q && wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else if (fire) begin
			armed_q <= 1'b0;
		end
	end
	// One-cycle notice; kind scrambled when idle so it is never reused
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hcmd_valid <= 1'b0;
			hcmd_kind <= 3'h0;
		end else begin
			hcmd_valid <= fire;
			hcmd_kind <= fire ? kind_q : ~kind_q;
		end
	end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the self-test controller
`timescale 1ns/1ps
`include "ost_regs.svh"
module tb;
	import ost_pkg::*;
	// ----
	// Signals
	// ----
	logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd_q;
	logic pready, pslverr, hcmd_valid, err_q;
	logic [2:0] hcmd_kind, hkind = 0;
	logic soft_rst = 0, media_fail = 0, hgo = 0, hslow = 0;
	ost_tf_s tf;
	logic sleep_req, standby_timer_ok, scan_active;
	logic [7:0] lf = 8'h03; // Random state
	int error_cnt = 0, n_checks = 0;
	always #5 clock = ~clock;
	// Short counts keep the run brief; a step still outlasts host notices
	ost_ctrl #(.SERVICE_CYC(50), .STEP_CYC(60)) dut (.*);
	ost_host_model host (.clock(clock), .nrst(nrst), .go(hgo),
		.kind(hkind), .slow(hslow), .bsy(tf.bsy),
		.hcmd_valid(hcmd_valid), .hcmd_kind(hcmd_kind));
	// ----
	// Tasks
	// ----
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t saw %h want %h", $time, s, e);
		end
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic tmo();
		error_cnt++;
		$display("ERROR %0t wait timed out", $time);
		print_verdict();
	endtask
	// Bounded wait: 0 busy, 1 scan, 2 sleep, 3 notice
	task automatic wt(input int s, input logic v);
		int n;
		n = 0;
		while ((s == 0 ? tf.bsy : s == 1 ? scan_active : s == 2 ?
			sleep_req : hcmd_valid) !== v && n < 30000) begin
			@(posedge clock);
			n++;
		end
		if (n == 30000) tmo();
	endtask
	// APB transfer, request held until ready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) tmo();
	endtask
	task automatic hc(input logic [2:0] k);
		@(posedge clock);
		lf = lfsr(lf);
		hgo <= 1'b1;
		hkind <= k;
		hslow <= lf[0];
		@(posedge clock);
		hgo <= 1'b0;
		wt(3, 1'b1);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		chk({tf, standby_timer_ok, scan_active}, 5'b01010);
		apb(0, `OST_PEND_OFF, 0);
		chk(rd_q, 32'h64);
		apb(0, 12'h020, 0);
		chk(err_q, 1'b1);
		apb(1, `OST_PEND_OFF, 32'h14);
		// Log set up before any test starts, never during one
		apb(1, `OST_CTRL_OFF, 32'h3);
		// Every captive code, selective last so its scan follows
		for (int c = 8'h81; c <= 8'h84; c++) begin
			apb(1, `OST_CMD_OFF, 32'h80000000 | c);
			wt(0, 1'b1);
			wt(0, 1'b0);
			apb(0, `OST_STAT_OFF, 0);
			chk(rd_q[15:8], 8'h00);
			chk(tf.err, 1'b0);
		end
		$display("captive test done");
		wt(1, 1'b1);
		apb(0, `OST_SPAN_OFF, 0);
		chk(rd_q[4:3], 2'b11);
		chk(rd_q[2:0] > 3'h5, 1'b1);
		apb(0, `OST_STAT_OFF, 0);
		chk(rd_q[15:0], 16'h0003);
		hc(OST_HC_OTHER);
		hc(OST_HC_STANDBY);
		hc(OST_HC_WAKE);
		wt(1, 1'b1);
		chk(scan_active, 1'b1);
		@(posedge clock);
		soft_rst <= 1'b1;
		@(posedge clock);
		soft_rst <= 1'b0;
		apb(0, `OST_SPAN_OFF, 0);
		chk(rd_q[4:3], 2'b10);
		wt(1, 1'b1);
		// Media errors during the remainder scan stay hidden
		media_fail <= 1'b1;
		wt(1, 1'b0);
		media_fail <= 1'b0;
		apb(0, `OST_SPAN_OFF, 0);
		chk(rd_q[4:3], 2'b00);
		apb(0, `OST_STAT_OFF, 0);
		chk(rd_q[7:0], 8'h02);
		chk(rd_q[15:8], 8'h00);
		$display("remainder scan test done");
		// Off-line tests, reserved code, both abort codes
		for (int i = 0; i < 2; i++) begin
			lf = lfsr(lf);
			apb(1, `OST_CMD_OFF, 32'h80000001 + lf[0]);
			chk(tf.bsy, 1'b0);
			apb(0, `OST_STAT_OFF, 0);
			chk(rd_q[15:12], 4'hF);
			apb(1, `OST_CMD_OFF, 32'h80000005 + lf[3:1]);
			apb(0, `OST_STAT_OFF, 0);
			chk(rd_q[15:12], 4'hF);
			apb(1, `OST_CMD_OFF, i ? 32'h8000000F : 32'h8000007F);
			apb(0, `OST_STAT_OFF, 0);
			chk(rd_q[15:12], 4'h1);
		end
		apb(1, `OST_CMD_OFF, 32'h80000003);
		hc(OST_HC_SLEEP);
		wt(2, 1'b1);
		apb(0, `OST_STAT_OFF, 0);
		chk(rd_q[15:12] == 4'hF, 1'b0);
		hc(OST_HC_WAKE);
		apb(1, `OST_CMD_OFF, 32'h80000000);
		apb(0, `OST_STAT_OFF, 0);
		chk(rd_q[7:0], 8'h03);
		$display("off-line test done");
		@(posedge clock);
		media_fail <= 1'b1;
		apb(1, `OST_CMD_OFF, 32'h80000084);
		wt(0, 1'b1);
		wt(0, 1'b0);
		apb(0, `OST_STAT_OFF, 0);
		chk(rd_q[15:12], `OST_ST_FAIL_READ);
		chk(scan_active, 1'b0);
		chk(tf.err, 1'b1);
		media_fail <= 1'b0;
		$display("failure test done");
		print_verdict();
	end
endmodule

/* File: verilog/ost_ctrl.sv */
// Off-line and captive self-test controller with APB register access
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ost_regs.svh"

module ost_ctrl
	import ost_pkg::*;
#(
	parameter int unsigned SERVICE_CYC = `OST_SERVICE_CYC,
	parameter int unsigned STEP_CYC = 1000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host command notice from transport, not an execute command
	input wire logic hcmd_valid,
	input wire logic [2:0] hcmd_kind,
	// Soft reset pulse from transport logic
	input wire logic soft_rst,
	// Media test engine feedback (same clock)
	input wire logic media_fail,
	// Task-file status and power outputs
	output ost_tf_s tf,
	output logic sleep_req,
	output logic standby_timer_ok,
	output logic scan_active
);

	// Routine flow: a start code moves idle to a run state; interrupting
	// host commands other than sleep park it in suspend; a selective test with the scan
	// flag set ends its spans and then runs the remainder scan, whose
	// pending flag survives a soft reset and restarts after a delay.

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ost_state_e st_q; // Routine state
	ost_state_e resume_q; // State left on suspend
	logic [7:0] sub_q; // Running subcommand
	logic [7:0] offst_q; // Off-line collection status
	logic [7:0] stst_q; // Self-test status byte
	ost_sel_s sel_q; // Selective log flags
	logic smart_en_q; // SMART enabled
	logic scan_en_q; // Remainder scan wanted
	logic [31:0] pend_q; // Pending delay in cycles
	// Counters are 32 bits so long pending delays never wrap
	logic [31:0] cnt_q; // Step or delay counter
	logic [31:0] svc_q; // Deadline counter
	logic cap_done_q; // Captive completion pulse
	logic [3:0] tenths_q; // Tenths remaining
	logic [7:0] last_cmd_q; // Last executed code

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Subcommand is a self-test (either mode)
	function automatic logic is_test(input logic [7:0] c);
		is_test = (c >= `OST_SUB_SHORT && c <= `OST_SUB_SEL) ||
			(c >= `OST_SUB_CAP_BASE && c <= `OST_SUB_CAP_SEL);
	endfunction

	// Subcommand is runnable at all; reserved/vendor codes refused
	// No routine starts for those, but last_cmd_q still records the code and the step count restarts
	function automatic logic is_known(input logic [7:0] c);
		is_known = (c <= `OST_SUB_SEL) ||
			(c >= `OST_SUB_CAP_BASE && c <= `OST_SUB_CAP_SEL);
	endfunction

	// Selective codes 4 and 132
	function automatic logic is_sel(input logic [7:0] c);
		is_sel = (c == `OST_SUB_SEL) || (c == `OST_SUB_CAP_SEL);
	endfunction

	// Either abort code
	function automatic logic is_abort(input logic [7:0] c);
		is_abort = (c == `OST_SUB_ABORT_A) ||
			(c == `OST_SUB_ABORT_B);
	endfunction

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic wr;
	logic rd_ok;
	logic cmd_wr;
	logic [7:0] cmd_code;
	logic running;
	ost_hcmd_e hk;

	// Writes land on the access edge, where pready is always high
	assign wr = psel && penable && pwrite;
	assign cmd_wr = wr && paddr == `OST_CMD_OFF && pwdata[`OST_CMD_GO];
	assign cmd_code = pwdata[7:0];
	assign hk = ost_hcmd_e'(hcmd_kind);
	assign running = st_q == OST_RUN_OFF || st_q == OST_RUN_CAP ||
		st_q == OST_REMAIN;
	// Single-cycle access phase, no wait states
	assign pready = 1'b1;

	// Read mux; unmapped offsets flag an error instead of aliasing
	always_comb begin
		rd_ok = 1'b1;
		unique case (paddr)
			`OST_CTRL_OFF: prdata = {29'h0, 1'b0, scan_en_q, smart_en_q};
			`OST_CMD_OFF: prdata = {24'h0, last_cmd_q};
			`OST_STAT_OFF: prdata = {13'h0, st_q, stst_q, offst_q};
			`OST_SPAN_OFF: prdata = {27'h0, sel_q};
			`OST_PEND_OFF: prdata = pend_q;
			`OST_WORK_OFF: prdata = svc_q;
			default: begin
				// Unmapped address reads zero and errors
				prdata = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end
	assign pslverr = psel && penable && !rd_ok;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Pending delay only changes while idle, so a wait in progress keeps
	// the value it started with
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			scan_en_q <= 1'b0;
			pend_q <= 32'h0000_0064;
		end else if (wr && paddr == `OST_CTRL_OFF &&
			st_q != OST_RUN_OFF) begin
			// Log flags frozen only while an off-line routine runs
			scan_en_q <= pwdata[`OST_CTRL_SCAN_EN];
		end else if (wr && paddr == `OST_PEND_OFF && st_q == OST_IDLE) begin
			pend_q <= pwdata;
		end
	end

	// SMART enable follows host commands and control writes
	// Host enable and disable commands win over a register write in the same cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			smart_en_q <= 1'b1;
		end else if (hcmd_valid && hk == OST_HC_DISABLE) begin
			smart_en_q <= 1'b0;
		end else if (hcmd_valid && hk == OST_HC_ENABLE) begin
			smart_en_q <= 1'b1;
		end else if (wr && paddr == `OST_CTRL_OFF) begin
			smart_en_q <= pwdata[`OST_CTRL_SMART_EN];
		end
	end

	// ------------------------------------------------------------
	// Service deadline counter
	// ------------------------------------------------------------
	// Counts from an interrupting command; the state machine acts in
	// the same cycle, so the count only proves the bound is met.
	// It saturates at the bound so software can read whether it was hit.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			svc_q <= 32'h0;
		end else if (hcmd_valid && running) begin
			svc_q <= 32'h1;
		end else if (svc_q != 32'h0 && svc_q < SERVICE_CYC) begin
			svc_q <= svc_q + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Routine state machine
	// ------------------------------------------------------------
	logic step_done;
	assign step_done = cnt_q >= STEP_CYC;

	// One process owns the routine: each event maps to exactly one of
	// start, suspend, resume or abort, taken in priority order below.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= OST_IDLE;
			resume_q <= OST_IDLE;
			sub_q <= 8'h00;
			offst_q <= `OST_OFF_NEVER;
			stst_q <= {`OST_ST_OK, 4'h0};
			sel_q <= '0;
			cnt_q <= 32'h0;
			tenths_q <= 4'h0;
			last_cmd_q <= 8'h00;
			cap_done_q <= 1'b0;
		end else begin
			cap_done_q <= 1'b0;
			// Progress is frozen while suspended, so a resume picks up
			// where it stopped instead of finishing a step at once
			if (st_q != OST_SUSP) begin
				cnt_q <= cnt_q + 32'h1;
			end
			if (soft_rst) begin
				// Only a pending remainder scan survives
				if (!sel_q.pending) begin
					if (st_q != OST_IDLE && is_test(sub_q)) begin
						stst_q <= {`OST_ST_RESET, 4'h0};
					end
					st_q <= OST_IDLE;
				end else begin
					// Pending scan survives; restart waits out the delay
					st_q <= OST_PEND;
					sel_q.active <= 1'b0;
					cnt_q <= 32'h0;
				end
			end else if (cmd_wr && smart_en_q && st_q != OST_RUN_CAP) begin
				// Captive runs lock out new starts until they complete
				last_cmd_q <= cmd_code;
				cnt_q <= 32'h0;
				if (is_abort(cmd_code)) begin
					// Abort any stage but a captive run, including remainder scan
					if (st_q != OST_IDLE) begin
						st_q <= OST_IDLE;
						stst_q <= {`OST_ST_HOST_ABORT, 4'h0};
						sel_q <= '0;
					end
				end else if (is_known(cmd_code)) begin
					// Old routine dropped, new one started
					sub_q <= cmd_code;
					sel_q <= '0;
					tenths_q <= 4'h9;
					if (cmd_code[7]) begin
						st_q <= OST_RUN_CAP;
						stst_q <= {`OST_ST_RUN, 4'h9};
					end else begin
						// Completion is immediate, routine follows
						st_q <= OST_RUN_OFF;
						if (cmd_code == `OST_SUB_COLLECT) begin
							offst_q <= `OST_OFF_PROG;
						end else begin
							stst_q <= {`OST_ST_RUN, 4'h9};
						end
					end
				end
			end else if (hcmd_valid && running && st_q != OST_RUN_CAP) begin
				// Captive runs hold busy, so the host cannot reach them here
				unique case (hk)
					OST_HC_SLEEP: begin
						// Self-test must abort; collection aborts too
						st_q <= OST_IDLE;
						if (is_test(sub_q)) begin
							stst_q <= {`OST_ST_HOST_ABORT, 4'h0};
						end else begin
							offst_q <= `OST_OFF_ABORT;
						end
					end
					default: begin
						// Suspend and later resume
						resume_q <= st_q;
						st_q <= OST_SUSP;
						if (sub_q == `OST_SUB_COLLECT) begin
							offst_q <= `OST_OFF_SUSP;
						end
					end
				endcase
			end else begin
				unique case (st_q)
					OST_IDLE: begin
					end
					OST_SUSP: begin
						// Standby, idle and sleep leave the routine parked
						// Ordinary commands resume at once
						if (hcmd_valid && smart_en_q &&
							(hk == OST_HC_OTHER || hk == OST_HC_WAKE ||
							hk == OST_HC_ENABLE)) begin
							st_q <= resume_q;
							if (sub_q == `OST_SUB_COLLECT) begin
								offst_q <= `OST_OFF_PROG;
							end
						end
					end
					OST_RUN_OFF, OST_RUN_CAP: begin
						if (is_test(sub_q) && media_fail) begin
							// Early stop on failure
							st_q <= OST_IDLE;
							stst_q <= {`OST_ST_FAIL_READ, tenths_q};
							cap_done_q <= st_q == OST_RUN_CAP;
							sel_q <= '0;
						end else if (step_done) begin
							cnt_q <= 32'h0;
							if (is_sel(sub_q)) begin
								sel_q.span <= sel_q.span + 3'h1;
							end
							if (tenths_q != 4'h0) begin
								tenths_q <= tenths_q - 4'h1;
								if (is_test(sub_q)) begin
									stst_q <= {`OST_ST_RUN, tenths_q - 4'h1};
								end
							end else if (is_sel(sub_q) && scan_en_q) begin
								// Either mode: a captive command completes
								// here and the scan goes on in background
								st_q <= OST_REMAIN;
								sel_q <= '{pending: 1'b1, active: 1'b1,
									span: `OST_SPAN_REMAIN};
								stst_q <= {`OST_ST_OK, 4'h0};
								offst_q <= `OST_OFF_PROG;
							end else begin
								st_q <= OST_IDLE;
								cap_done_q <= st_q == OST_RUN_CAP;
								if (sub_q == `OST_SUB_COLLECT) begin
									offst_q <= `OST_OFF_DONE;
								end else begin
									stst_q <= {`OST_ST_OK, 4'h0};
								end
							end
						end
					end
					OST_PEND: begin
						// Wait pending time after power-up
						sel_q.active <= 1'b0;
						if (cnt_q >= pend_q) begin
							st_q <= OST_REMAIN;
							sel_q.active <= 1'b1;
							cnt_q <= 32'h0;
						end
					end
					OST_REMAIN: begin
						// A sleep here leaves pending set for the restart
						// Errors here are swallowed, never reported
						if (step_done) begin
							st_q <= OST_IDLE;
							sel_q <= '0;
							offst_q <= `OST_OFF_DONE;
						end
					end
				endcase
			end
			// Power-up with pending flag held in log resumes via delay
			// (also reached when sleep ends a scan with pending set)
			if (!soft_rst && st_q == OST_IDLE && sel_q.pending) begin
				st_q <= OST_PEND;
				cnt_q <= 32'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Task-file and power outputs
	// ------------------------------------------------------------
	// Busy only while a captive test holds the command
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tf <= '{bsy: 1'b0, drdy: 1'b1, err: 1'b0};
		end else if (st_q == OST_RUN_CAP && !cap_done_q) begin
			tf <= '{bsy: 1'b1, drdy: 1'b0, err: 1'b0};
		end else begin
			// Off-line routines never raise busy; the error flag marks a
			// failed captive test until the host issues the next command
			tf <= '{bsy: 1'b0, drdy: 1'b1,
				err: !cmd_wr && (tf.err || (cap_done_q &&
				stst_q[7:4] == `OST_ST_FAIL_READ))};
		end
	end

	// Power-side outputs; the standby timer is held off while a routine
	// runs or waits out its pending delay, but not while it is suspended
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sleep_req <= 1'b0;
			standby_timer_ok <= 1'b1;
			scan_active <= 1'b0;
		end else begin
			sleep_req <= hcmd_valid && hk == OST_HC_SLEEP;
			standby_timer_ok <= !(running || st_q == OST_PEND);
			scan_active <= st_q == OST_REMAIN;
		end
	end

endmodule

/* File: verilog/ost_pkg.sv */
// Types shared by the self-test controller
package ost_pkg;
	// Host command classes seen by the controller
	typedef enum logic [2:0] {
		OST_HC_OTHER,
		OST_HC_SLEEP,
		OST_HC_DISABLE,
		OST_HC_ENABLE,
		OST_HC_STANDBY,
		OST_HC_IDLE,
		OST_HC_WAKE
	} ost_hcmd_e;

	// Routine states
	typedef enum logic [2:0] {
		OST_IDLE,
		OST_RUN_OFF,
		OST_RUN_CAP,
		OST_SUSP,
		OST_PEND,
		OST_REMAIN
	} ost_state_e;

	// Status bits seen by host transport
	typedef struct packed {
		logic bsy;
		logic drdy;
		logic err;
	} ost_tf_s;

	// Selective log flags
	typedef struct packed {
		logic pending;
		logic active;
		logic [2:0] span;
	} ost_sel_s;
endpackage

/* File: verilog/ost_regs.svh */
// Register offsets, field positions, codes and timing counts for self-test
`ifndef OST_REGS_SVH
`define OST_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OST_CTRL_OFF 12'h000
`define OST_CMD_OFF 12'h004
`define OST_STAT_OFF 12'h008
`define OST_SPAN_OFF 12'h00C
`define OST_PEND_OFF 12'h010
`define OST_WORK_OFF 12'h014

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define OST_CTRL_SMART_EN 0
`define OST_CTRL_SCAN_EN 1
`define OST_CTRL_ABORT_BIT 2
`define OST_CMD_GO 31

// ------------------------------------------------------------
// Subcommand and status codes
// ------------------------------------------------------------
`define OST_SUB_COLLECT 8'h00
`define OST_SUB_SHORT 8'h01
`define OST_SUB_EXT 8'h02
`define OST_SUB_CONV 8'h03
`define OST_SUB_SEL 8'h04
`define OST_SUB_ABORT_A 8'h0F
`define OST_SUB_ABORT_B 8'h7F
`define OST_SUB_CAP_BASE 8'h81
`define OST_SUB_CAP_SEL 8'h84
`define OST_ST_OK 4'h0
`define OST_ST_HOST_ABORT 4'h1
`define OST_ST_RESET 4'h2
`define OST_ST_FAIL_READ 4'h7
`define OST_ST_RUN 4'hF
`define OST_OFF_NEVER 8'h00
`define OST_OFF_DONE 8'h02
`define OST_OFF_PROG 8'h03
`define OST_OFF_SUSP 8'h04
`define OST_OFF_ABORT 8'h05
`define OST_SPAN_NUM 3'h5
`define OST_SPAN_REMAIN 3'h6

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define OST_CLK_MHZ 100
`define OST_SERVICE_S 2
`define OST_SERVICE_CYC (`OST_SERVICE_S * `OST_CLK_MHZ * 1000000)

`endif
